// >>> hw/mxb_cfg.svh
`ifndef MXB_CFG_SVH
`define MXB_CFG_SVH

// register offsets on the register port
`define MXB_OFF_PORT0       8'h00
`define MXB_OFF_PORT1       8'h01
`define MXB_OFF_STATUS      8'hfc
`define MXB_OFF_P3_CFG      8'hf7
`define MXB_OFF_P01_CFG     8'hf8

// port01_function_config fields
`define MXB_P01_LO_IN       0
`define MXB_P01_LO_ADDR     1
`define MXB_P01_STACK_INT   2
`define MXB_P01_P1_LO       3
`define MXB_P01_P1_HI       4
`define MXB_P01_EXT_TIM     5
`define MXB_P01_HI_IN       6
`define MXB_P01_HI_ADDR     7
`define MXB_P1_MODE_OUT     2'h0
`define MXB_P1_MODE_IN      2'h1
`define MXB_P1_MODE_AD      2'h2
`define MXB_P1_MODE_HIZ     2'h3
// ports inputs, stack internal, extended timing, p1 input
`define MXB_P01_RESET       8'h6d

// port3_function_config fields
`define MXB_P3_DM_LO        3
`define MXB_P3_DM_HI        4
`define MXB_P3_DM_A         2'h2
`define MXB_P3_DM_B         2'h1
`define MXB_P3_RESET        8'h00

// timing: clocks per state, first program address
`define MXB_STATE_CLKS      2
`define MXB_RESET_PC        16'h000c
`define MXB_ALL_ONES        8'hff
`define MXB_NIB_ONES        4'hf

`endif

// >>> hw/mxb_pkg.sv
package mxb_pkg;

  typedef enum logic [1:0] {
    MXB_ST_IDLE = 2'b00,
    MXB_ST_ADDR = 2'b01,
    MXB_ST_DATA = 2'b10,
    MXB_ST_END  = 2'b11
  } mxb_state_e;

  typedef enum logic [1:0] {
    MXB_K_FETCH = 2'b00,
    MXB_K_CODE  = 2'b01,
    MXB_K_DATA  = 2'b10,
    MXB_K_STACK = 2'b11
  } mxb_kind_e;

  typedef struct packed {
    mxb_kind_e   kind;
    logic        write;
    logic        internal;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mxb_req_s;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } mxb_port_s;

  typedef struct packed {
    logic as_n;
    logic as_oe;
    logic ds_n;
    logic ds_oe;
    logic rw;
    logic rw_oe;
    logic dm_n;
    logic dm_oe;
  } mxb_ctl_s;

  typedef struct packed {
    mxb_state_e  state;
    logic [3:0]  cnt;
    mxb_req_s    req;
    logic        ext;
    logic        shown;
    logic        dm;
    logic [7:0]  rdata;
    logic        rsp_valid;
    logic [7:0]  port01_function_config;
    logic [7:0]  p3m;
    logic [7:0]  p0_out;
    logic [7:0]  p1_out;
    logic [7:0]  reg_rdata;
    logic        started;
    logic        exec_start;
  } mxb_core_s;

endpackage

// >>> hw/mxb_bus.sv
`include "mxb_cfg.svh"

module mxb_bus #(
  parameter int unsigned STATE_CLKS = `MXB_STATE_CLKS
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  input  wire logic              i_req_valid,
  input  wire mxb_pkg::mxb_req_s i_req,
  output logic                   o_req_ready,
  output logic                   o_rsp_valid,
  output logic [7:0]             o_rsp_rdata,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic [7:0]             o_reg_rdata,
  input  wire logic [7:0]        i_p0_in,
  output mxb_pkg::mxb_port_s     o_p0,
  input  wire logic [7:0]        i_p1_in,
  output mxb_pkg::mxb_port_s     o_p1,
  output mxb_pkg::mxb_ctl_s      o_ctl,
  output logic                   o_exec_start,
  output logic [15:0]            o_exec_addr
);
  import mxb_pkg::*;

  localparam logic [3:0] CNT_STATE = 4'(STATE_CLKS - 1);
  // extended state adds one more state time to the data strobe
  localparam logic [3:0] CNT_EXT   = 4'(2 * STATE_CLKS - 1);

  mxb_core_s q;
  mxb_core_s d;

  logic [1:0] p1_mode;
  logic       bus_on;
  logic       shared;
  logic       lo_addr;
  logic       hi_addr;
  logic       stack_int;
  logic       ext_tim;
  logic       dm_en;
  logic       busy;
  logic [3:0] p0_lo_val;
  logic [3:0] p0_hi_val;
  logic       req_ext;
  logic       req_dm;
  logic       code_wr;

  assign p1_mode   = q.port01_function_config[`MXB_P01_P1_HI:`MXB_P01_P1_LO];
  assign bus_on    = (p1_mode == `MXB_P1_MODE_AD);
  assign shared    = (p1_mode == `MXB_P1_MODE_HIZ);
  assign lo_addr   = q.port01_function_config[`MXB_P01_LO_ADDR];
  assign hi_addr   = q.port01_function_config[`MXB_P01_HI_ADDR];
  assign stack_int = q.port01_function_config[`MXB_P01_STACK_INT];
  assign ext_tim   = q.port01_function_config[`MXB_P01_EXT_TIM];
  assign dm_en     =
    (q.p3m[`MXB_P3_DM_HI:`MXB_P3_DM_LO] == `MXB_P3_DM_A) ||
    (q.p3m[`MXB_P3_DM_HI:`MXB_P3_DM_LO] == `MXB_P3_DM_B);
  assign busy      = (q.state != MXB_ST_IDLE);

  assign p0_lo_val = q.port01_function_config[`MXB_P01_LO_IN] ? i_p0_in[3:0] : q.p0_out[3:0];
  assign p0_hi_val = q.port01_function_config[`MXB_P01_HI_IN] ? i_p0_in[7:4] : q.p0_out[7:4];

  // a code-space load that writes is always taken outside
  assign code_wr = (i_req.kind == MXB_K_CODE) && i_req.write;
  always_comb begin
    req_ext = 1'b0;
    unique case (i_req.kind)
      MXB_K_DATA:  req_ext = 1'b1;
      MXB_K_STACK: req_ext = !stack_int;
      MXB_K_CODE:  req_ext = !i_req.internal || code_wr;
      MXB_K_FETCH: req_ext = !i_req.internal;
    endcase
  end
  assign req_dm = dm_en && ((i_req.kind == MXB_K_DATA) ||
                  ((i_req.kind == MXB_K_STACK) && !stack_int));

  always_comb begin
    d            = q;
    d.rsp_valid  = 1'b0;
    d.exec_start = 1'b0;
    d.reg_rdata  = 8'h00;

    if (!q.started) begin
      d.started    = 1'b1;
      d.exec_start = 1'b1;
    end

    // register writes; port bits in use by the bus are protected
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `MXB_OFF_P01_CFG: d.port01_function_config = i_reg_wdata;
        `MXB_OFF_P3_CFG:  d.p3m  = i_reg_wdata;
        `MXB_OFF_PORT0: begin
          if (!lo_addr) begin
            d.p0_out[3:0] = i_reg_wdata[3:0];
          end
          if (!hi_addr) begin
            d.p0_out[7:4] = i_reg_wdata[7:4];
          end
        end
        `MXB_OFF_PORT1: begin
          if (!bus_on && !shared) begin
            d.p1_out = i_reg_wdata;
          end
        end
        default: ;
      endcase
    end

    // mode registers are write only and read back as zero
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `MXB_OFF_PORT0: begin
          d.reg_rdata = {hi_addr ? `MXB_NIB_ONES : p0_hi_val,
                         lo_addr ? `MXB_NIB_ONES : p0_lo_val};
        end
        `MXB_OFF_PORT1: begin
          if (bus_on || shared) begin
            d.reg_rdata = `MXB_ALL_ONES;
          end else if (p1_mode == `MXB_P1_MODE_IN) begin
            d.reg_rdata = i_p1_in;
          end else begin
            d.reg_rdata = q.p1_out;
          end
        end
        `MXB_OFF_STATUS: begin
          d.reg_rdata = {4'h0, q.dm, busy, shared, bus_on};
        end
        default: d.reg_rdata = 8'h00;
      endcase
    end

    unique case (q.state)
      MXB_ST_IDLE: begin
        if (i_req_valid) begin
          d.req   = i_req;
          // without the bus the cycle runs silently at the unextended length
          d.ext   = req_ext && bus_on;
          d.shown = bus_on;
          d.dm    = req_dm && bus_on;
          d.rdata = 8'h00;
          d.cnt   = CNT_STATE;
          d.state = MXB_ST_ADDR;
        end
      end
      MXB_ST_ADDR: begin
        if (q.cnt == 4'h0) begin
          // internal access time unchanged by extended timing
          d.cnt   = (q.ext && ext_tim) ? CNT_EXT : CNT_STATE;
          d.state = MXB_ST_DATA;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      MXB_ST_DATA: begin
        if (q.cnt == 4'h0) begin
          if (q.ext && !q.req.write) begin
            d.rdata = i_p1_in;
          end
          d.cnt   = CNT_STATE;
          d.state = MXB_ST_END;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      MXB_ST_END: begin
        if (q.cnt == 4'h0) begin
          d.rsp_valid = 1'b1;
          d.state     = MXB_ST_IDLE;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      q            <= '0;
      q.state      <= MXB_ST_IDLE;
      q.req.kind   <= MXB_K_FETCH;
      q.port01_function_config       <= `MXB_P01_RESET;
      q.p3m        <= `MXB_P3_RESET;
    end else begin
      q <= d;
    end
  end

  // control strobes; address, data and direction strobes float together in shared mode, data space select does not
  always_comb begin
    o_ctl.as_oe = !shared;
    o_ctl.ds_oe = !shared;
    o_ctl.rw_oe = !shared;
    // low for the first clock of the first state, rising mid-state
    o_ctl.as_n  = !(q.shown && (q.state == MXB_ST_ADDR) &&
                    (q.cnt == CNT_STATE));
    o_ctl.ds_n  = !(q.ext && (q.state == MXB_ST_DATA));
    o_ctl.rw    = !(q.ext && busy && q.req.write);
    o_ctl.dm_oe = dm_en;
    o_ctl.dm_n  = !(q.dm && busy);
  end

  // port 1: address in the first state, then write data or released
  always_comb begin
    o_p1.o  = q.p1_out;
    o_p1.oe = 8'h00;
    if (bus_on) begin
      if (q.state == MXB_ST_ADDR) begin
        o_p1.o  = q.req.addr[7:0];
        o_p1.oe = q.shown ? `MXB_ALL_ONES : 8'h00;
      end else begin
        o_p1.o  = q.req.wdata;
        // held through the closing state so data outlasts the strobe
        o_p1.oe = (q.ext && q.req.write &&
                   ((q.state == MXB_ST_DATA) || (q.state == MXB_ST_END)))
                  ? `MXB_ALL_ONES : 8'h00;
      end
    end else if (p1_mode == `MXB_P1_MODE_OUT) begin
      o_p1.oe = `MXB_ALL_ONES;
    end
  end

  // port 0 nibbles: upper address held for the whole cycle and after
  always_comb begin
    o_p0.o[3:0]  = lo_addr ? q.req.addr[11:8] : q.p0_out[3:0];
    o_p0.o[7:4]  = hi_addr ? q.req.addr[15:12] : q.p0_out[7:4];
    o_p0.oe[3:0] = lo_addr ? {4{!shared}}
                           : {4{!q.port01_function_config[`MXB_P01_LO_IN]}};
    o_p0.oe[7:4] = hi_addr ? {4{!shared}}
                           : {4{!q.port01_function_config[`MXB_P01_HI_IN]}};
  end

  assign o_req_ready  = !busy;
  assign o_rsp_valid  = q.rsp_valid;
  assign o_rsp_rdata  = q.rdata;
  assign o_reg_rdata  = q.reg_rdata;
  assign o_exec_start = q.exec_start;
  assign o_exec_addr  = `MXB_RESET_PC;

endmodule // mxb_bus

// >>> verif/mxb_bus_monitor.sv
module mxb_bus_monitor #(
  parameter int unsigned STATE_CLKS = 2
) (
  input wire logic               i_core_clk,
  input wire logic               i_reset,
  input wire logic               i_req_valid,
  input wire mxb_pkg::mxb_req_s  i_req,
  input wire logic               o_req_ready,
  input wire logic               o_rsp_valid,
  input wire logic [7:0]         i_reg_addr,
  input wire logic [7:0]         i_reg_wdata,
  input wire logic               i_reg_wr,
  input wire logic               i_reg_rd,
  input wire logic [7:0]         o_reg_rdata,
  input wire mxb_pkg::mxb_port_s o_p1,
  input wire mxb_pkg::mxb_ctl_s  o_ctl
);
  import mxb_pkg::*;
  // mode registers are write-only, so their state is shadowed here
  logic [7:0] p01_q;
  logic [7:0] p3_q;
  logic       wr_q;
  wire        take = i_req_valid && o_req_ready;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      p01_q <= 8'h6d;
      p3_q  <= 8'h00;
      wr_q  <= 1'b0;
    end else begin
      if (i_reg_wr && i_reg_addr == 8'hf8) p01_q <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == 8'hf7) p3_q <= i_reg_wdata;
      if (take) wr_q <= i_req.write;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_cycle;
    (!o_rsp_valid) [*5] ##[1:7] o_rsp_valid;
  endsequence
  a_as_pulse: assert property ($fell(o_ctl.as_n) |=> o_ctl.as_n)
    else $error("address strobe low for more than one cycle");
  a_rw_only_write: assert property (!o_ctl.rw && o_ctl.rw_oe |-> wr_q)
    else $error("direction low outside a write");
  a_write_drives: assert property (!o_ctl.ds_n && !o_ctl.rw && o_ctl.ds_oe
    |-> o_p1.oe == 8'hff) else $error("write data not driven");
  a_read_frees: assert property (!o_ctl.ds_n && o_ctl.rw && o_ctl.ds_oe
    |-> o_p1.oe == 8'h00) else $error("bus driven during read");
  a_cycle_len: assert property (take |=> s_cycle)
    else $error("machine cycle length out of range");
  a_idle_high: assert property (o_req_ready && p01_q[4:3] != 2'b11
    |-> o_ctl.as_n && o_ctl.ds_n) else $error("strobe low while idle");
  a_bus_reads_ones: assert property (i_reg_rd && i_reg_addr == 8'h01 &&
    p01_q[4:3] == 2'b10 |=> o_reg_rdata == 8'hff)
    else $error("bus port read not all ones");
  a_shared_float: assert property (p01_q[4:3] == 2'b11 &&
    $past(p01_q[4:3]) == 2'b11 |-> o_p1.oe == 8'h00 && !o_ctl.as_oe &&
    !o_ctl.ds_oe && !o_ctl.rw_oe) else $error("shared bus driven");
  a_dm_routed: assert property (!o_ctl.dm_n && o_ctl.dm_oe
    |-> p3_q[4:3] inside {2'b10, 2'b01})
    else $error("data space select without routing");
endmodule // mxb_bus_monitor

bind mxb_bus mxb_bus_monitor #(.STATE_CLKS(STATE_CLKS)) i_mxb_bus_monitor (
  .i_core_clk, .i_reset, .i_req_valid, .i_req, .o_req_ready, .o_rsp_valid,
  .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_p1,
  .o_ctl
);

// >>> verif/mxb_ext_mem.sv
module mxb_ext_mem (
  input  wire logic               i_core_clk,
  input  wire mxb_pkg::mxb_port_s i_p1,
  input  wire mxb_pkg::mxb_ctl_s  i_ctl,
  output logic [7:0]              o_level
);
  import mxb_pkg::*;
  logic [7:0] mem_q [256];
  logic [7:0] adr_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [7:0] drv;
  wire        act = i_ctl.ds_oe && !i_ctl.ds_n;
  // no pull-up on the bus: released lines toggle so stale data never passes
  assign drv = (act && i_ctl.rw) ? mem_q[adr_q] : ~last_q;
  assign o_level = (i_p1.oe & i_p1.o) | (~i_p1.oe & drv);
  always @(posedge i_core_clk) begin
    last_q <= o_level;
    if (!i_ctl.as_n) adr_q <= o_level;
    if (act && !i_ctl.rw) mem_q[adr_q] <= o_level;
  end
endmodule // mxb_ext_mem

// >>> verif/muxed_external_memory_bus_tb.sv
module muxed_external_memory_bus_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mxb_pkg::*;
  logic        core_clk = 1'b0, reset = 1'b1, req_valid = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, req_ready, rsp_valid, exec_start;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, p0_in = 8'h00;
  logic [7:0]  rsp_rdata, reg_rdata, p1_lvl, rv;
  logic [15:0] exec_addr, rnd = 16'h88b7;
  mxb_req_s    req = '0;
  mxb_port_s   p0, p1;
  mxb_ctl_s    ctl;
  int          bad_count = 0, total_checks = 0, ds_cnt = 0, dm_cnt = 0;
  int          ds_len, cyc_n;
  mxb_bus #(.STATE_CLKS(2)) i_mxb_bus (
    .i_core_clk(core_clk), .i_reset(reset), .i_req_valid(req_valid),
    .i_req(req), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid),
    .o_rsp_rdata(rsp_rdata), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_p0_in(p0_in), .o_p0(p0), .i_p1_in(p1_lvl), .o_p1(p1), .o_ctl(ctl),
    .o_exec_start(exec_start), .o_exec_addr(exec_addr)
  );
  mxb_ext_mem i_mxb_ext_mem (
    .i_core_clk(core_clk), .i_p1(p1), .i_ctl(ctl), .o_level(p1_lvl)
  );
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (ctl.ds_n === 1'b0) ds_cnt <= ds_cnt + 1;
    if (ctl.dm_n === 1'b0) dm_cnt <= dm_cnt + 1;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic reg_wr_t(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_rd_t(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // engine is idle whenever this is entered, so the raise edge is taken
  task automatic bus(input mxb_kind_e k, input logic w, input logic i,
                     input logic [15:0] a, input logic [7:0] d);
    int d0;
    d0 = ds_cnt;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{k, w, i, a, d};
    @(posedge core_clk);
    req_valid <= 1'b0;
    cyc_n = 0;
    do begin
      @(posedge core_clk);
      #1 cyc_n++;
    end while (rsp_valid !== 1'b1 && cyc_n < 40);
    if (rsp_valid !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end else begin
      rv = rsp_rdata;
      ds_len = ds_cnt - d0;
    end
  endtask
  initial begin
    logic [15:0] a, ex;
    logic [7:0]  b;
    int          n0;
    ex = 16'h0000;
    repeat (11) @(posedge core_clk);
    #1 check({ctl.as_n, ctl.ds_n, ctl.rw, ctl.dm_oe, p1.oe | p0.oe, 4'h0},
             16'he000);
    @(posedge core_clk);
    reset <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      #1 if (exec_start === 1'b1) ex = exec_addr;
    end
    check(ex, 16'h000c);
    reg_rd_t(8'hfc);
    check({8'h00, rv}, 16'h0000);
    @(posedge core_clk);
    p0_in <= rnd[7:0];
    reg_wr_t(8'hf8, 8'h56);
    reg_wr_t(8'h01, 8'h12);
    reg_rd_t(8'h01);
    check({8'h00, rv}, 16'h00ff);
    reg_rd_t(8'h00);
    check({8'h00, rv}, {8'h00, p0_in[7:4], 4'hf});
    reg_wr_t(8'h00, 8'ha5);
    for (int j = 0; j < 5; j++) begin
      rnd = lfsr(rnd);
      a = (j == 0) ? 16'h0fff : rnd;
      b = rnd[15:8] ^ 8'h96;
      bus(MXB_K_DATA, 1'b1, 1'b0, a, b);
      bus(MXB_K_DATA, 1'b0, 1'b0, a, 8'h00);
      check({8'h00, rv}, {8'h00, b});
      check(16'(ds_len), 16'h0002);
      check({12'h000, p0.o[3:0] & p0.oe[3:0]}, {12'h000, a[11:8]});
    end
    n0 = cyc_n;
    check(16'(n0), 16'h0006);
    reg_wr_t(8'hf8, 8'h76);
    bus(MXB_K_DATA, 1'b0, 1'b0, a, 8'h00);
    check(16'(ds_len), 16'h0004);
    check(16'(cyc_n - n0), 16'h0002);
    bus(MXB_K_FETCH, 1'b0, 1'b1, 16'h0123, 8'h00);
    check(16'(ds_len), 16'h0000);
    bus(MXB_K_CODE, 1'b1, 1'b1, 16'h0045, 8'h77);
    check(16'(ds_len), 16'h0004);
    for (int j = 0; j < 3; j++) begin
      reg_wr_t(8'hf7, 8'h10 >> j);
      n0 = dm_cnt;
      bus(MXB_K_DATA, 1'b0, 1'b0, a, 8'h00);
      check({15'h0000, dm_cnt != n0}, {15'h0000, j < 2});
    end
    reg_wr_t(8'hf7, 8'h10);
    // internal stack first, then external stack with full upper address
    for (int s = 0; s < 2; s++) begin
      reg_wr_t(8'hf8, (s == 1) ? 8'hf2 : 8'h76);
      repeat (3) bus(MXB_K_FETCH, 1'b0, 1'b1, 16'h000c, 8'h00);
      n0 = dm_cnt;
      bus(MXB_K_STACK, 1'b1, 1'b0, a, 8'h3c);
      check(16'(ds_len), (s == 1) ? 16'h0004 : 16'h0000);
      check({15'h0000, dm_cnt != n0}, {15'h0000, s == 1});
    end
    bus(MXB_K_DATA, 1'b0, 1'b0, a, 8'h00);
    check({8'h00, rv}, 16'h003c);
    check({8'h00, p0.o}, {8'h00, a[15:8]});
    reg_wr_t(8'hf8, 8'h5e);
    @(posedge core_clk);
    #1 check({1'b0, ctl.as_oe, ctl.ds_oe, ctl.rw_oe, p1.oe, p0.oe[3:0]},
             16'h0000);
    // back to plain ports: earlier bus-mode writes to port bits held by the bus must be gone
    reg_wr_t(8'hf8, 8'h00);
    reg_rd_t(8'h01);
    check({8'h00, rv}, 16'h0000);
    check({8'h00, p0.o}, 16'h00a0);
    report_and_stop();
  end
endmodule // muxed_external_memory_bus_tb
